// ==== sop_core_model.sv ====
// Behavioural model of the cell array answering read requests.
`timescale 1ns/10ps
`default_nettype none
`include "sop_map.svh"
module sop_core_model (
   input  wire logic                   rd_req,   // Read pulse.
   input  wire logic [`SOP_ADDR_W-1:0] addr,     // Word address.
   output logic                        rd_valid, // Data pulse.
   output logic [`SOP_DQ_W-1:0]        rd_data   // Read word.
);
   // Answers in the request cycle; the port takes it at the next edge.
   assign rd_valid = rd_req;
   // Outside a valid cycle the inverse shows, so stale data is never trusted.
   assign rd_data  = {addr[9:0] ^ 10'h2A5, addr} ^ {32{~rd_req}};
endmodule : sop_core_model
`default_nettype wire

// ==== sop_map.svh ====
// Constant map of the synchronous OTP read and program port.
`ifndef SOP_MAP_SVH
`define SOP_MAP_SVH
`define SOP_ROW_W       13
`define SOP_COL_W       9
`define SOP_ADDR_W      22
`define SOP_DQ_W        32
`define SOP_HALF_W      16
`define SOP_FIFO_DEPTH  16
`define SOP_LAT_DEF     3'h6
`define SOP_LAT_OFS     3'h2
`define SOP_BL8_DEF     1'b0
`define SOP_ILV_DEF     1'b0
`define SOP_MRS_LOCK    2'h3
`define SOP_MRS_BL_BIT  0
`define SOP_MRS_ILV_BIT 3
`define SOP_MRS_LAT_LSB 4
`define SOP_MRS_LAT_MSB 6
`define SOP_BL4         4'h4
`define SOP_BL8         4'h8
`define SOP_MASK4       3'h3
`define SOP_MASK8       3'h7
`endif

// ==== sop_pkg.sv ====
// Types shared by the synchronous OTP read and program port.
`include "sop_map.svh"
package sop_pkg;
   typedef enum logic [1:0] {
      SOP_IDLE  = 2'b00,
      SOP_PDOWN = 2'b01,
      SOP_BURST = 2'b10,
      SOP_PROG  = 2'b11
   } sop_state_t;

   // Active-low command strobes that travel together.
   typedef struct packed {
      logic cs_n;
      logic row_strobe_n;
      logic column_strobe_n;
      logic mode_set_strobe_n;
   } sop_cmd_t;

   // Complete state of the port controller.
   typedef struct packed {
      sop_state_t                st;
      logic                      cke_q;
      logic [`SOP_ROW_W-1:0]     row;
      logic [`SOP_COL_W-1:0]     col;
      logic [2:0]                beat;
      logic [3:0]                issue_left;
      logic [3:0]                out_left;
      logic                      wide;
      logic                      wait_rd;
      logic                      discard;
      logic [2:0]                lat_cnt;
      logic [2:0]                lat;
      logic                      bl8;
      logic                      ilv;
      logic [1:0]                lock;
      logic                      dqm1;
      logic [`SOP_DQ_W-1:0]      dq_out;
      logic                      oe_lo;
      logic                      oe_hi;
      logic                      ras_q;
      logic                      cas_q;
      logic                      ce_q;
      logic [`SOP_ROW_W-1:0]     prow;
      logic [`SOP_COL_W-1:0]     pcol;
      logic                      prd_pend;
      logic                      rd_req;
      logic                      prog_req;
      logic [`SOP_ADDR_W-1:0]    caddr;
      logic [`SOP_HALF_W-1:0]    pdata;
   } sop_port_t;
endpackage : sop_pkg

// ==== sop_port.sv ====
// Pin-level controller of the synchronous OTP with its read FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "sop_map.svh"

// Read data FIFO with valid and ready on both sides.
module sop_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input  wire logic         sys_clk,   // System clock.
   input  wire logic         sys_rst,   // Asynchronous reset, high.
   input  wire logic         clr,       // Drops all stored words.
   input  wire logic         in_valid,  // Word offered.
   output logic              in_ready,  // Room for a word.
   input  wire logic [W-1:0] in_data,   // Word written.
   output logic              out_valid, // Word available.
   input  wire logic         out_ready, // Word taken.
   output logic [W-1:0]      out_data   // Oldest word.
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } sop_fifo_t;

   sop_fifo_t    s_reg;
   sop_fifo_t    s_next;
   logic [W-1:0] mem [D];
   logic         do_wr;
   logic         do_rd;

   // Handshakes follow the fill count directly.
   assign in_ready  = (s_reg.cnt != (AW+1)'(D));
   assign out_valid = (s_reg.cnt != '0);
   assign out_data  = mem[s_reg.rp];
   assign do_wr     = in_valid & in_ready & ~clr;
   assign do_rd     = out_valid & out_ready & ~clr;

   // Pointer and count update; wrap relies on a power-of-two depth.
   always_comb begin
      s_next = s_reg;
      if (clr) begin
         s_next = '0;
      end else begin
         if (do_wr) begin
            s_next.wp = s_reg.wp + 1'b1;
         end
         if (do_rd) begin
            s_next.rp = s_reg.rp + 1'b1;
         end
         s_next.cnt = s_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   // State register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Storage array, written without reset.
   always_ff @(posedge sys_clk) begin
      if (do_wr) begin
         mem[s_reg.wp] <= in_data;
      end
   end
endmodule : sop_fifo

// Operation
// - Select low or open gives synchronous read.
// - Select high enters static programming.
// - Synchronous inputs sample on the rising clock.
// - Commands taken only with chip select low.
// - Low clock enable freezes the next cycle.
// - Row and column share thirteen inputs; row uses all.
// - Column is eight bits in 32-bit mode, nine in 16-bit.
// - Data driven only in read cycles, else floating.
// - Mask sampled high floats data two cycles later.
// - Width select per read: high 32-bit, low 16-bit.
// - 16-bit mode floats the upper sixteen lines.
// - Mux select low takes row and column inputs at once.
// - Mux select high latches row on row strobe rise.
// - Mux select high latches column on column strobe rise.
// - Mux select picks column inputs or strobes.
// - Low sixteen lines take program data, return read data.
// - Unused pins never affect behaviour.
// - Clock enable high ends power down; row kept.
module sop_port #(
   parameter int FIFO_DEPTH = `SOP_FIFO_DEPTH
) (
   input  wire logic                   sys_clk,                // Clock.
   input  wire logic                   sys_rst,                // Reset.
   input  wire logic                   static_mode_select,     // 1: program.
   input  wire logic                   address_multiplex_select, // Mux.
   input  wire sop_pkg::sop_cmd_t      sync_cmd,               // Strobes.
   input  wire logic                   clock_enable,           // Clock mask.
   input  wire logic                   output_mask,            // Out mask.
   input  wire logic                   width_select,           // 1: 32-bit.
   input  wire logic [`SOP_ROW_W-1:0]  address_inputs,         // Address.
   input  wire logic [`SOP_COL_W-1:0]  separate_column_inputs, // Column.
   input  wire logic                   chip_enable_n,          // Prog CE.
   input  wire logic                   output_enable_n,        // Prog OE.
   input  wire logic [`SOP_HALF_W-1:0] data_lines_in,          // Pin level.
   output logic [`SOP_DQ_W-1:0]        data_lines_out,         // Drive value.
   output logic                        data_lines_oe_lo,       // Low half.
   output logic                        data_lines_oe_hi,       // High half.
   output logic                        core_rd_req,            // Read pulse.
   output logic                        core_wide,              // 32-bit read.
   output logic [`SOP_ADDR_W-1:0]      core_addr,              // Word addr.
   input  wire logic [`SOP_DQ_W-1:0]   core_rd_data,           // Read data.
   input  wire logic                   core_rd_valid,          // Data pulse.
   output logic                        core_prog_req,          // Prog pulse.
   output logic [`SOP_HALF_W-1:0]      core_prog_data          // Prog data.
);
   import sop_pkg::*;

   sop_port_t             r_reg;
   sop_port_t             r_next;
   logic                  fifo_clr;
   logic                  fifo_push;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_pop;
   logic [`SOP_DQ_W-1:0]  fifo_out_data;
   logic                  cmd_ok;
   logic                  cmd_row;
   logic                  cmd_read;
   logic                  cmd_mrs;
   logic                  cmd_stop;

   // Column of one burst beat, sequential or interleaved.
   function automatic logic [`SOP_COL_W-1:0] sop_beat_col(
      input logic [`SOP_COL_W-1:0] base,
      input logic [2:0]            beat,
      input logic                  bl8,
      input logic                  ilv,
      input logic                  wide
   );
      logic [2:0]            mask;
      logic [2:0]            low;
      logic [`SOP_COL_W-1:0] col;
      mask = bl8 ? `SOP_MASK8 : `SOP_MASK4;
      low  = ilv ? (base[2:0] ^ beat) : (base[2:0] + beat);
      col  = {base[`SOP_COL_W-1:3], (base[2:0] & ~mask) | (low & mask)};
      if (wide) begin
         col[`SOP_COL_W-1] = 1'b0;
      end
      return col;
   endfunction : sop_beat_col

   // Command decode; chip select low and no lockout.
   assign cmd_ok   = ~sync_cmd.cs_n & (r_reg.lock == '0);
   assign cmd_mrs  = cmd_ok & ~sync_cmd.row_strobe_n
                   & ~sync_cmd.column_strobe_n & ~sync_cmd.mode_set_strobe_n;
   assign cmd_row  = cmd_ok & ~sync_cmd.row_strobe_n
                   & sync_cmd.column_strobe_n & sync_cmd.mode_set_strobe_n;
   assign cmd_read = cmd_ok & sync_cmd.row_strobe_n
                   & ~sync_cmd.column_strobe_n & sync_cmd.mode_set_strobe_n;
   assign cmd_stop = cmd_ok & sync_cmd.column_strobe_n
                   & ~sync_cmd.mode_set_strobe_n;

   // Queue core answers outside program mode unless their burst was cancelled.
   assign fifo_push = core_rd_valid & r_reg.wait_rd & ~r_reg.discard
                    & (r_reg.st != SOP_PROG);

   // Next-state logic for both operating modes.
   always_comb begin
      r_next          = r_reg;
      r_next.rd_req   = 1'b0;
      r_next.prog_req = 1'b0;
      r_next.ras_q    = sync_cmd.row_strobe_n;
      r_next.cas_q    = sync_cmd.column_strobe_n;
      r_next.ce_q     = chip_enable_n;
      r_next.cke_q    = clock_enable;
      fifo_clr        = 1'b0;
      fifo_pop        = 1'b0;
      if (core_rd_valid) begin
         r_next.wait_rd = 1'b0;
         r_next.discard = 1'b0;
      end
      if (static_mode_select) begin
         // Static programming; of the sync pins only the row and column strobes are used.
         r_next.st         = SOP_PROG;
         r_next.issue_left = '0;
         r_next.out_left   = '0;
         r_next.oe_hi      = 1'b0;
         r_next.discard    = r_reg.wait_rd & ~core_rd_valid;
         fifo_clr          = 1'b1;
         if (address_multiplex_select) begin
            if (sync_cmd.row_strobe_n & ~r_reg.ras_q) begin
               r_next.prow = address_inputs;
            end
            if (sync_cmd.column_strobe_n & ~r_reg.cas_q) begin
               r_next.pcol = address_inputs[`SOP_COL_W-1:0];
            end
            r_next.caddr = {r_reg.prow, r_reg.pcol};
         end else begin
            r_next.caddr = {address_inputs, separate_column_inputs};
         end
         // Program pulse on chip enable fall, output enable high.
         if (~chip_enable_n & r_reg.ce_q & output_enable_n) begin
            r_next.prog_req = 1'b1;
            r_next.pdata    = data_lines_in;
            r_next.oe_lo    = 1'b0;
         end
         // Both enables low: verify read on the low half.
         if (~chip_enable_n & ~output_enable_n) begin
            if (~r_reg.prd_pend & ~r_reg.wait_rd) begin
               r_next.rd_req   = 1'b1;
               r_next.prd_pend = 1'b1;
               r_next.wait_rd  = 1'b1;
            end
            if (core_rd_valid & r_reg.prd_pend) begin
               r_next.dq_out   = {{`SOP_HALF_W{1'b0}},
                                  core_rd_data[`SOP_HALF_W-1:0]};
               r_next.oe_lo    = 1'b1;
               r_next.prd_pend = 1'b0;
            end
         end else begin
            r_next.oe_lo    = 1'b0;
            r_next.prd_pend = 1'b0;
         end
      end else begin
         if (r_reg.st == SOP_PROG) begin
            r_next.st       = SOP_IDLE;
            r_next.oe_lo    = 1'b0;
            r_next.prd_pend = 1'b0;
         end
         // Core reads run on under suspend; an answer frees the next slot.
         if ((r_reg.issue_left != '0) & fifo_in_ready
             & (~r_reg.wait_rd | core_rd_valid)) begin
            r_next.rd_req     = 1'b1;
            r_next.wait_rd    = 1'b1;
            r_next.caddr      = {r_reg.row, sop_beat_col(r_reg.col,
                                 r_reg.beat, r_reg.bl8, r_reg.ilv,
                                 r_reg.wide)};
            r_next.beat       = r_reg.beat + 3'h1;
            r_next.issue_left = r_reg.issue_left - 4'h1;
         end
         if (r_reg.cke_q & (r_reg.st != SOP_PROG)) begin
            // Internal clock runs: sample, decode and step outputs.
            r_next.dqm1 = output_mask;
            if (r_reg.lock != '0) begin
               r_next.lock = r_reg.lock - 2'h1;
            end
            // Output stage; mask sampled one edge back floats the pins.
            if (r_reg.lat_cnt != '0) begin
               r_next.lat_cnt = r_reg.lat_cnt - 3'h1;
            end else if (r_reg.out_left != '0) begin
               if (fifo_out_valid) begin
                  fifo_pop        = 1'b1;
                  r_next.out_left = r_reg.out_left - 4'h1;
                  r_next.dq_out   = r_reg.wide ? fifo_out_data :
                     {{`SOP_HALF_W{1'b0}}, fifo_out_data[`SOP_HALF_W-1:0]};
                  r_next.oe_lo    = ~r_reg.dqm1;
                  r_next.oe_hi    = ~r_reg.dqm1 & r_reg.wide;
               end else begin
                  r_next.oe_lo = 1'b0;
                  r_next.oe_hi = 1'b0;
               end
            end else begin
               r_next.oe_lo = 1'b0;
               r_next.oe_hi = 1'b0;
               if (r_reg.st == SOP_BURST) begin
                  r_next.st = SOP_IDLE;
               end
            end
            if (cmd_stop & (r_reg.st == SOP_BURST)) begin
               // Burst stop or precharge ends the burst at once.
               r_next.issue_left = '0;
               r_next.out_left   = '0;
               r_next.oe_lo      = 1'b0;
               r_next.oe_hi      = 1'b0;
               r_next.st         = SOP_IDLE;
               r_next.discard    = r_reg.wait_rd & ~core_rd_valid;
               fifo_clr          = 1'b1;
            end else if (cmd_row) begin
               r_next.row = address_inputs;
            end else if (cmd_mrs & (r_reg.st == SOP_IDLE)) begin
               r_next.bl8  = address_inputs[`SOP_MRS_BL_BIT];
               r_next.ilv  = address_inputs[`SOP_MRS_ILV_BIT];
               r_next.lat  =
                  address_inputs[`SOP_MRS_LAT_MSB:`SOP_MRS_LAT_LSB];
               r_next.lock = `SOP_MRS_LOCK;
            end else if (cmd_read) begin
               // Read: latch column and width, restart the burst.
               r_next.wide       = width_select;
               r_next.col        = width_select ?
                  {1'b0, address_inputs[`SOP_COL_W-2:0]} :
                  address_inputs[`SOP_COL_W-1:0];
               r_next.beat       = '0;
               r_next.issue_left = r_reg.bl8 ? `SOP_BL8 : `SOP_BL4;
               r_next.out_left   = r_reg.bl8 ? `SOP_BL8 : `SOP_BL4;
               r_next.lat_cnt    = r_reg.lat - `SOP_LAT_OFS;
               r_next.st         = SOP_BURST;
               r_next.rd_req     = 1'b0;
               r_next.wait_rd    = r_reg.wait_rd & ~core_rd_valid;
               r_next.discard    = r_reg.wait_rd & ~core_rd_valid;
               r_next.oe_lo      = 1'b0;
               r_next.oe_hi      = 1'b0;
               fifo_clr          = 1'b1;
            end
            if ((r_reg.st == SOP_IDLE) & ~clock_enable & sync_cmd.cs_n) begin
               r_next.st = SOP_PDOWN;
            end
         end else if (r_reg.st == SOP_PDOWN) begin
            // Power down freezes all; row address kept.
            if (clock_enable) begin
               r_next.st = SOP_IDLE;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg       <= '0;
         r_reg.st    <= SOP_IDLE;
         r_reg.cke_q <= 1'b1;
         r_reg.lat   <= `SOP_LAT_DEF;
         r_reg.bl8   <= `SOP_BL8_DEF;
         r_reg.ilv   <= `SOP_ILV_DEF;
         r_reg.ras_q <= 1'b1;
         r_reg.cas_q <= 1'b1;
         r_reg.ce_q  <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Read data queue to the output stage.
   sop_fifo #(
      .W (`SOP_DQ_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .clr       (fifo_clr),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   (core_rd_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // Registered outputs.
   assign data_lines_out   = r_reg.dq_out;
   assign data_lines_oe_lo = r_reg.oe_lo;
   assign data_lines_oe_hi = r_reg.oe_hi;
   assign core_rd_req      = r_reg.rd_req;
   assign core_wide        = r_reg.wide & (r_reg.st != SOP_PROG);
   assign core_addr        = r_reg.caddr;
   assign core_prog_req    = r_reg.prog_req;
   assign core_prog_data   = r_reg.pdata;
endmodule : sop_port
`default_nettype wire

// ==== sop_port_props.sv ====
// Concurrent checks on the OTP port pins.
`timescale 1ns/10ps
`default_nettype none
`include "sop_map.svh"
module sop_port_props (
   input wire logic                   sys_clk,            // Clock.
   input wire logic                   sys_rst,            // Reset.
   input wire logic                   static_mode_select, // Mode.
   input wire logic                   address_multiplex_select, // Mux.
   input wire sop_pkg::sop_cmd_t      sync_cmd,           // Strobes.
   input wire logic                   clock_enable,       // Clock mask.
   input wire logic                   output_mask,        // Out mask.
   input wire logic [`SOP_ROW_W-1:0]  address_inputs,     // Address.
   input wire logic [`SOP_COL_W-1:0]  separate_column_inputs, // Column.
   input wire logic                   chip_enable_n,      // Prog CE.
   input wire logic                   output_enable_n,    // Prog OE.
   input wire logic [`SOP_HALF_W-1:0] data_lines_in,      // Pin level.
   input wire logic                   data_lines_oe_lo,   // Low drive.
   input wire logic                   data_lines_oe_hi,   // High drive.
   input wire logic [`SOP_ADDR_W-1:0] core_addr,          // Word addr.
   input wire logic                   core_prog_req,      // Prog pulse.
   input wire logic [`SOP_HALF_W-1:0] core_prog_data      // Prog data.
);
   import sop_pkg::*;
   logic cke_reg;
   // Clock enable of the previous edge; high after reset.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) cke_reg <= 1'b1;
      else cke_reg <= clock_enable;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_mask_float: assert property (
      output_mask && cke_reg && clock_enable && !static_mode_select
      |-> ##2 !data_lines_oe_lo && !data_lines_oe_hi)
      else $error("masked data still driven");
   a_suspend_hold: assert property (
      !clock_enable && !static_mode_select ##1 !static_mode_select
      |=> $stable(data_lines_oe_lo) && $stable(data_lines_oe_hi))
      else $error("moved in suspend");
   a_prog_half: assert property (
      static_mode_select ##1 static_mode_select |-> !data_lines_oe_hi)
      else $error("upper half driven");
   a_prog_pulse: assert property (
      static_mode_select && $past(static_mode_select)
      && $fell(chip_enable_n) && output_enable_n
      |=> core_prog_req && core_prog_data == $past(data_lines_in))
      else $error("bad program pulse");
   a_prog_cause: assert property (
      core_prog_req |-> $past(static_mode_select)
      && !$past(chip_enable_n) && $past(output_enable_n))
      else $error("stray program pulse");
   a_sync_quiet: assert property (
      !static_mode_select && !$past(static_mode_select) |-> !core_prog_req)
      else $error("pulse in sync mode");
   a_flat_addr: assert property (
      (static_mode_select && !address_multiplex_select
      && $stable(address_inputs) && $stable(separate_column_inputs)) [*2]
      |-> core_addr == {address_inputs, separate_column_inputs})
      else $error("full address not taken");
   a_row_latch: assert property (
      static_mode_select && $past(static_mode_select)
      && address_multiplex_select && $rose(sync_cmd.row_strobe_n)
      |-> ##2 core_addr[21:9] == $past(address_inputs, 2))
      else $error("row not latched");
   a_col_latch: assert property (
      static_mode_select && $past(static_mode_select)
      && address_multiplex_select && $rose(sync_cmd.column_strobe_n)
      |-> ##2 core_addr[8:0] == $past(address_inputs[8:0], 2))
      else $error("column not latched");
   a_prog_release: assert property (
      (static_mode_select && (chip_enable_n || output_enable_n)) [*2]
      |=> !data_lines_oe_lo)
      else $error("drive kept");
endmodule : sop_port_props
bind sop_port sop_port_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .static_mode_select(static_mode_select),
   .address_multiplex_select(address_multiplex_select),
   .sync_cmd(sync_cmd), .clock_enable(clock_enable),
   .output_mask(output_mask), .address_inputs(address_inputs),
   .separate_column_inputs(separate_column_inputs),
   .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
   .data_lines_in(data_lines_in), .data_lines_oe_lo(data_lines_oe_lo),
   .data_lines_oe_hi(data_lines_oe_hi), .core_addr(core_addr),
   .core_prog_req(core_prog_req), .core_prog_data(core_prog_data));
`default_nettype wire

// ==== sop_port_tb.sv ====
// Self-checking testbench of the OTP read and program port.
`timescale 1ns/10ps
`default_nettype none
module sop_port_tb;
   import sop_pkg::*;
   localparam int LAT = 6; // Reset latency.
   typedef struct packed {
      logic wide; logic [12:0] row; logic [8:0] col; logic [8:0] c0;
   } sop_row_t;
   sop_row_t rows [4] = '{'{1'b0, 13'h1FFF, 9'h1FE, 9'h1FE},
      '{1'b1, 13'h0000, 9'h0FF, 9'h0FF}, '{1'b1, 13'h0ABC, 9'h103, 9'h003},
      '{1'b0, 13'h1234, 9'h101, 9'h101}};
   logic sys_clk = 1'b0, sys_rst = 1'b1, static_mode_select, clock_enable;
   logic address_multiplex_select, output_mask, width_select;
   logic chip_enable_n, output_enable_n, data_lines_oe_lo, data_lines_oe_hi;
   logic core_rd_req, core_wide, core_rd_valid, core_prog_req;
   sop_cmd_t sync_cmd;
   logic [12:0] address_inputs;
   logic [8:0]  separate_column_inputs;
   logic [15:0] data_lines_in, core_prog_data;
   logic [31:0] data_lines_out, core_rd_data, w;
   logic [21:0] core_addr;
   int fail_count = 0, compares = 0, cyc = 0;
   sop_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .static_mode_select(static_mode_select),
      .address_multiplex_select(address_multiplex_select),
      .sync_cmd(sync_cmd), .clock_enable(clock_enable),
      .output_mask(output_mask), .width_select(width_select),
      .address_inputs(address_inputs),
      .separate_column_inputs(separate_column_inputs),
      .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
      .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
      .data_lines_oe_lo(data_lines_oe_lo), .data_lines_oe_hi(data_lines_oe_hi),
      .core_rd_req(core_rd_req), .core_wide(core_wide), .core_addr(core_addr),
      .core_rd_data(core_rd_data), .core_rd_valid(core_rd_valid),
      .core_prog_req(core_prog_req), .core_prog_data(core_prog_data));
   sop_core_model u_core (
      .rd_req(core_rd_req), .addr(core_addr), .rd_valid(core_rd_valid),
      .rd_data(core_rd_data));
   // 5 ns clock.
   always #2.5 sys_clk = ~sys_clk;
   // Timeout guard.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         end_of_test();
      end
   end
   function automatic logic [31:0] exp_word(input logic [12:0] r,
                                            input logic [8:0]  c);
      return {{r[0], c} ^ 10'h2A5, r, c};
   endfunction : exp_word
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // One burst: mask beat mb, suspend at step ts, command taken or not.
   task automatic rd(input sop_row_t r, input int mb, input int ts,
                     input logic take, input logic new_row);
      int k;
      logic on;
      if (new_row) begin
         sync_cmd = 4'h3;
         address_inputs = r.row;
         step(1);
      end
      sync_cmd = take ? 4'h5 : 4'hD;
      address_inputs = {4'h0, r.col};
      width_select = r.wide;
      for (int t = 0; t <= LAT + 3; t++) begin
         step(1);
         sync_cmd = 4'hF;
         output_mask = (t == LAT - 3 + mb);
         clock_enable = (t != ts);
         k = t - LAT + 1;
         on = take && k >= 0 && k < 4 && k != mb;
         w = exp_word(r.row, {r.c0[8:2], r.c0[1:0] + k[1:0]});
         if (ts < 0 && k >= -1) begin
            chk(32'(data_lines_oe_lo), 32'(on));
            chk(32'(data_lines_oe_hi), 32'(on && r.wide));
            if (take && k >= 0) chk(32'(core_wide), 32'(r.wide));
            if (on) chk(data_lines_out, r.wide ? w : {16'h0000, w[15:0]});
         end
      end
   endtask : rd
   // Table of bursts, then awkward cases.
   initial begin
      static_mode_select = 1'b0;
      address_multiplex_select = 1'b1;
      sync_cmd = 4'hF;
      clock_enable = 1'b1;
      output_mask = 1'b0;
      width_select = 1'b0;
      address_inputs = 13'h0000;
      separate_column_inputs = 9'h1AA;
      chip_enable_n = 1'b0;
      output_enable_n = 1'b0;
      data_lines_in = 16'hA5A5;
      step(20);
      chk(32'({data_lines_oe_lo, data_lines_oe_hi, core_rd_req}), 0);
      sys_rst = 1'b0;
      step(1);
      foreach (rows[i]) rd(rows[i], -1, -1, 1'b1, 1'b1);
      rd(rows[3], 1, -1, 1'b1, 1'b0);
      rd(rows[3], -1, -1, 1'b0, 1'b0);
      rd(rows[3], -1, LAT, 1'b1, 1'b0);
      step(8);
      clock_enable = 1'b0;
      step(4);
      clock_enable = 1'b1;
      step(1);
      rd(rows[3], -1, -1, 1'b1, 1'b0);
      static_mode_select = 1'b1;
      address_multiplex_select = 1'b0;
      chip_enable_n = 1'b1;
      output_enable_n = 1'b1;
      address_inputs = 13'h15A3;
      separate_column_inputs = 9'h0C7;
      data_lines_in = 16'hBEEF;
      step(3);
      chip_enable_n = 1'b0;
      for (int n = 0; n < 4 && core_prog_req !== 1'b1; n++) step(1);
      chk(32'(core_prog_req), 32'h1);
      chk(32'(core_prog_data), 32'h0000BEEF);
      chk(32'(core_addr), {10'h000, 13'h15A3, 9'h0C7});
      step(1);
      chip_enable_n = 1'b1;
      address_multiplex_select = 1'b1;
      separate_column_inputs = 9'h1FF;
      sync_cmd = 4'hB;
      address_inputs = 13'h0E1D;
      step(1);
      sync_cmd = 4'hF;
      step(1);
      sync_cmd = 4'hD;
      address_inputs = 13'h0042;
      step(1);
      sync_cmd = 4'hF;
      step(1);
      address_inputs = 13'h1555;
      step(3);
      chk(32'(core_addr), {10'h000, 13'h0E1D, 9'h042});
      chip_enable_n = 1'b0;
      output_enable_n = 1'b0;
      for (int n = 0; n < 8 && data_lines_oe_lo !== 1'b1; n++) step(1);
      w = exp_word(13'h0E1D, 9'h042);
      chk(32'(data_lines_oe_lo), 32'h1);
      chk(32'(data_lines_out[15:0]), {16'h0000, w[15:0]});
      chk(32'(data_lines_oe_hi), 32'h0);
      output_enable_n = 1'b1;
      step(3);
      chk(32'(data_lines_oe_lo), 32'h0);
      static_mode_select = 1'b0;
      step(3);
      chk(32'({data_lines_oe_lo, data_lines_oe_hi}), 0);
      end_of_test();
   end
endmodule : sop_port_tb
`default_nettype wire
